/* File: pwm_channel_pkg.sv */
// Constants for one PWM timer channel: register map, fields, reset values
package pwm_channel_pkg;
  localparam int          CNT_W        = 10;
  localparam int          VIEW_W       = 16;
  localparam int          PIN_N        = 8;
  localparam int          DUTY_N       = 4;
  localparam int          DUTY_W       = 11;
  localparam int          OTS_BIT      = 10;
  localparam logic [15:0] CNT_PRESET   = 16'hFC00;
  localparam logic [5:0]  CNT_HIGH     = 6'h3F;

  localparam logic [1:0]  ADDR_CTRL    = 2'h0;
  localparam logic [1:0]  ADDR_OE      = 2'h1;
  localparam logic [1:0]  ADDR_POL     = 2'h2;

  localparam int          IE_BIT       = 5;
  localparam int          FLAG_BIT     = 4;
  localparam int          RUN_BIT      = 3;
  localparam int          CKS_LSB      = 0;
  localparam logic [1:0]  CTRL_FIXED   = 2'h3;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  localparam int          PRE_W        = 4;
  localparam logic [2:0]  CKS_DIV1     = 3'h0;
  localparam logic [2:0]  CKS_DIV2     = 3'h1;
  localparam logic [2:0]  CKS_DIV4     = 3'h2;
  localparam logic [2:0]  CKS_DIV8     = 3'h3;
  localparam logic [3:0]  PRE_MASK2    = 4'h1;
  localparam logic [3:0]  PRE_MASK4    = 4'h3;
  localparam logic [3:0]  PRE_MASK8    = 4'h7;
  localparam logic [3:0]  PRE_MASK16   = 4'hF;
endpackage

/* File: pwm_prescaler.sv */
// Counter clock divider producing a one-cycle count tick
`timescale 1ns/100ps
module pwm_prescaler
  import pwm_channel_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [2:0] clock_select_i,
  output logic            tick_o
);
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic [PRE_W-1:0] mask;

  always_comb begin
    case (clock_select_i)
      CKS_DIV1: mask = '0;
      CKS_DIV2: mask = PRE_MASK2;
      CKS_DIV4: mask = PRE_MASK4;
      CKS_DIV8: mask = PRE_MASK8;
      default:  mask = PRE_MASK16;
    endcase
    tick_o  = run_i && ((pre_ff & mask) == mask);
    nxt_pre = run_i ? pre_ff + 1'b1 : '0;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end
endmodule // pwm_prescaler

/* File: pwm_channel.sv */
// One PWM channel: control registers, period counter and eight outputs
`timescale 1ns/100ps
module pwm_channel
  import pwm_channel_pkg::*;
#(
  parameter int PINS = PIN_N
)(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [1:0]            reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [7:0]            reg_wdata_i,
  output logic      [7:0]            reg_rdata_o,
  input  wire logic [VIEW_W-1:0]     cycle_register_i,
  input  wire logic [DUTY_N*DUTY_W-1:0] duty_buffer_i,
  input  wire logic                  transfer_ack_i,
  input  wire logic                  transfer_disable_select_i,
  output logic                       match_irq_o,
  output logic                       cycle_match_o,
  output logic      [PINS-1:0]       pwm_o
);
  logic                     ie_ff;
  logic                     nxt_ie;
  logic                     run_ff;
  logic                     nxt_run;
  logic [2:0]               cks_ff;
  logic [2:0]               nxt_cks;
  logic                     flag_ff;
  logic                     nxt_flag;
  logic                     read_seen_ff;
  logic                     nxt_read_seen;
  logic [7:0]               oe_ff;
  logic [7:0]               nxt_oe;
  logic [7:0]               pol_ff;
  logic [7:0]               nxt_pol;
  logic [7:0]               rdata_ff;
  logic [7:0]               nxt_rdata;
  logic [CNT_W-1:0]         cnt_ff;
  logic [CNT_W-1:0]         nxt_cnt;
  logic [DUTY_N*DUTY_W-1:0] duty_ff;
  logic [DUTY_N*DUTY_W-1:0] nxt_duty;
  logic [PINS-1:0]          pin_ff;
  logic [PINS-1:0]          nxt_pin;
  logic                     tick;
  logic                     match;
  logic                     ctrl_wr;
  logic                     ctrl_rd;
  logic                     xfer_clear;
  logic [VIEW_W-1:0]        cnt_view;
  logic [7:0]               ctrl_view;

  pwm_prescaler u_prescaler (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n_i),
    .run_i          (run_ff),
    .clock_select_i (cks_ff),
    .tick_o         (tick)
  );

  // Control register strobes and transfer clear decoded once
  always_comb begin
    ctrl_wr    = reg_wr_i && (reg_addr_i == ADDR_CTRL);
    ctrl_rd    = reg_rd_i && (reg_addr_i == ADDR_CTRL);
    xfer_clear = transfer_ack_i && !transfer_disable_select_i;
  end

  // Counter as seen against the 16-bit cycle register
  always_comb begin
    cnt_view = run_ff ? {CNT_HIGH, cnt_ff} : CNT_PRESET;
    match    = run_ff && tick && (cnt_view == cycle_register_i);
  end

  // Control fields: interrupt enable, run and clock select
  always_comb begin
    nxt_ie  = ie_ff;
    nxt_run = run_ff;
    nxt_cks = cks_ff;
    if (ctrl_wr) begin
      nxt_ie  = reg_wdata_i[IE_BIT];
      nxt_run = reg_wdata_i[RUN_BIT];
      nxt_cks = reg_wdata_i[CKS_LSB +: 3];
    end
  end

  // Control field registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ie_ff  <= 1'b0;
      run_ff <= 1'b0;
      cks_ff <= '0;
    end else begin
      ie_ff  <= nxt_ie;
      run_ff <= nxt_run;
      cks_ff <= nxt_cks;
    end
  end

  // Match flag and its read-before-clear arm; a match wins over any clear
  always_comb begin
    nxt_flag      = flag_ff;
    nxt_read_seen = read_seen_ff;
    if (ctrl_rd && flag_ff) begin
      nxt_read_seen = 1'b1;
    end
    if (ctrl_wr && !reg_wdata_i[FLAG_BIT] && read_seen_ff) begin
      nxt_flag      = 1'b0;
      nxt_read_seen = 1'b0;
    end
    if (xfer_clear) begin
      nxt_flag      = 1'b0;
      nxt_read_seen = 1'b0;
    end
    if (match) begin
      nxt_flag = 1'b1;
    end
  end

  // Flag registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_ff      <= 1'b0;
      read_seen_ff <= 1'b0;
    end else begin
      flag_ff      <= nxt_flag;
      read_seen_ff <= nxt_read_seen;
    end
  end

  // Output enable and polarity bytes
  always_comb begin
    nxt_oe  = oe_ff;
    nxt_pol = pol_ff;
    if (reg_wr_i && (reg_addr_i == ADDR_OE)) begin
      nxt_oe = reg_wdata_i;
    end
    if (reg_wr_i && (reg_addr_i == ADDR_POL)) begin
      nxt_pol = reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      oe_ff  <= '0;
      pol_ff <= '0;
    end else begin
      oe_ff  <= nxt_oe;
      pol_ff <= nxt_pol;
    end
  end

  // Read port; the period counter has no address
  always_comb begin
    ctrl_view = {CTRL_FIXED, ie_ff, flag_ff, run_ff, cks_ff};
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CTRL: nxt_rdata = ctrl_view;
        ADDR_OE:   nxt_rdata = oe_ff;
        ADDR_POL:  nxt_rdata = pol_ff;
        default:   nxt_rdata = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Period counter and duty transfer on cycle match
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_duty = duty_ff;
    if (!run_ff) begin
      nxt_cnt = CNT_PRESET[CNT_W-1:0];
    end else if (match) begin
      nxt_cnt  = '0;
      nxt_duty = duty_buffer_i;
    end else if (tick) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= '0;
      duty_ff <= '0;
    end else begin
      cnt_ff  <= nxt_cnt;
      duty_ff <= nxt_duty;
    end
  end

  // Per-pin waveform: duty buffer k serves pins 2k and 2k+1
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    localparam logic ODD_PIN = 1'(i % 2);
    logic [DUTY_W-1:0] duty_sel;
    logic              active;
    always_comb begin
      duty_sel = nxt_duty[(i/2)*DUTY_W +: DUTY_W];
      active   = run_ff && (nxt_cnt < duty_sel[CNT_W-1:0]) && (duty_sel[OTS_BIT] == ODD_PIN);
    end
    assign nxt_pin[i] = oe_ff[i] ? (active ^ pol_ff[i]) : pol_ff[i];
  end

  // Registered pins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign reg_rdata_o   = rdata_ff;
  assign match_irq_o   = flag_ff && ie_ff;
  assign cycle_match_o = match;
  assign pwm_o         = pin_ff;
endmodule // pwm_channel

/* File: pwm_channel_monitor.sv */
// Port checker for one PWM channel
`timescale 1ns/100ps
module pwm_channel_monitor
  import pwm_channel_pkg::*;
#(parameter int PINS = PIN_N)
(
  input wire logic            ref_clk_i,
  input wire logic            rst_n_i,
  input wire logic [1:0]      reg_addr_i,
  input wire logic            reg_wr_i,
  input wire logic            reg_rd_i,
  input wire logic [7:0]      reg_wdata_i,
  input wire logic [7:0]      reg_rdata_o,
  input wire logic            transfer_ack_i,
  input wire logic            transfer_disable_select_i,
  input wire logic            match_irq_o,
  input wire logic            cycle_match_o,
  input wire logic [PINS-1:0] pwm_o
);
  logic [7:0] ctl_ff, pol_ff, nxt_ctl, nxt_pol;
  logic       wc;
  logic       cause;
  always_comb begin
    wc      = reg_wr_i && reg_addr_i == ADDR_CTRL;
    cause   = cycle_match_o || (wc && reg_wdata_i[IE_BIT]);
    nxt_ctl = wc ? reg_wdata_i : ctl_ff;
    nxt_pol = reg_wr_i && reg_addr_i == ADDR_POL ? reg_wdata_i : pol_ff;
  end
  always_ff @(posedge ref_clk_i) begin
    ctl_ff <= rst_n_i ? nxt_ctl : BYTE_ZERO;
    pol_ff <= rst_n_i ? nxt_pol : BYTE_ZERO;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_flag; reg_rd_i && reg_addr_i == ADDR_CTRL && match_irq_o; endsequence
  sequence wr_clear; wc && !reg_wdata_i[FLAG_BIT] && reg_wdata_i[IE_BIT] && !cycle_match_o; endsequence
  AST_RD_FIXED: assert property (reg_rd_i && reg_addr_i == ADDR_CTRL |=> reg_rdata_o[7:6] == CTRL_FIXED)
    else $error("top control bits wrong");
  AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == BYTE_ZERO)
    else $error("unmapped read not zero");
  AST_MATCH_SETS: assert property (cycle_match_o && ctl_ff[IE_BIT] && !wc |=> match_irq_o)
    else $error("match gave no irq");
  AST_IRQ_CAUSE: assert property ($rose(match_irq_o) |-> $past(cause))
    else $error("irq without cause");
  AST_IRQ_HOLD: assert property (
    match_irq_o && !(wc && !(reg_wdata_i[FLAG_BIT] && reg_wdata_i[IE_BIT]))
    && !(transfer_ack_i && !transfer_disable_select_i) |=> match_irq_o) else $error("irq dropped");
  AST_XFER_CLEAR: assert property (
    transfer_ack_i && !transfer_disable_select_i && !cycle_match_o && !wc |=> !match_irq_o)
    else $error("transfer kept irq");
  AST_SW_CLEAR: assert property (rd_flag ##2 wr_clear |=> !match_irq_o)
    else $error("clear write kept irq");
  AST_STOP_IDLE: assert property (
    !ctl_ff[RUN_BIT] && $stable(ctl_ff) && $stable(pol_ff) |-> pwm_o == pol_ff) else $error("stopped pins active");
endmodule // pwm_channel_monitor
bind pwm_channel pwm_channel_monitor #(.PINS(PINS)) i_monitor (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .transfer_ack_i(transfer_ack_i), .transfer_disable_select_i(transfer_disable_select_i),
  .match_irq_o(match_irq_o), .cycle_match_o(cycle_match_o), .pwm_o(pwm_o));

/* File: power_stage_model.sv */
// Power stage load measuring the last high time of pin A
`timescale 1ns/100ps
module power_stage_model (
  input  wire logic [7:0]  pwm_i,
  input  wire logic        ref_clk_i,
  output logic      [15:0] width_o
);
  logic [15:0] high_ff = 16'h0000;
  always @(posedge ref_clk_i) begin
    high_ff <= pwm_i[0] ? high_ff + 16'h0001 : 16'h0000;
    if (!pwm_i[0] && high_ff != 16'h0000) width_o <= high_ff;
  end
endmodule // power_stage_model

/* File: tb.sv */
// Self-checking bench for one PWM channel
`timescale 1ns/100ps
module tb;
  import pwm_channel_pkg::*;
  logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0, dsel = 1'b0, irq, match;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00, rdata, pwm;
  logic [15:0] width;
  int          n_fail = 0, total_checks = 0, cycles = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  pwm_channel i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cycle_register_i(16'hFC09), .duty_buffer_i(44'h003),
    .transfer_ack_i(ack), .transfer_disable_select_i(dsel), .match_irq_o(irq), .cycle_match_o(match), .pwm_o(pwm));
  power_stage_model i_load (.pwm_i(pwm), .ref_clk_i(ref_clk_i), .width_o(width));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude;
    end
  end
  task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(negedge ref_clk_i);
    {wr, rd} = 2'b00;
  endtask
  task automatic xfer(input logic d);
    @(negedge ref_clk_i);
    {ack, dsel} = {1'b1, d};
    @(negedge ref_clk_i);
    ack = 1'b0;
  endtask
  task automatic wait_match;
    int i;
    for (i = 0; i < 400 && match !== 1'b1; i++) @(negedge ref_clk_i);
    chk(match, 1'b1);
    @(negedge ref_clk_i);
  endtask
  task automatic t_regs;
    access(1'b0, ADDR_CTRL, 8'h00);
    chk(rdata, 8'hC0);
    access(1'b1, ADDR_CTRL, 8'h07);
    access(1'b0, ADDR_CTRL, 8'h00);
    chk(rdata, 8'hC7);
    access(1'b1, ADDR_OE, 8'h01);
    access(1'b1, ADDR_POL, 8'h5A);
    access(1'b0, ADDR_POL, 8'h00);
    chk(rdata, 8'h5A);
    access(1'b0, 2'h3, 8'h00);
    chk(rdata, 8'h00);
    chk(pwm, 8'h5A);
  endtask
  task automatic t_irq;
    access(1'b1, ADDR_CTRL, 8'h28);
    wait_match;
    chk(irq, 1'b1);
    access(1'b1, ADDR_CTRL, 8'h38);
    access(1'b0, ADDR_CTRL, 8'h00);
    chk(rdata, 8'hF8);
    access(1'b1, ADDR_CTRL, 8'h28);
    chk(irq, 1'b0);
    wait_match;
    xfer(1'b1);
    chk(irq, 1'b1);
    xfer(1'b0);
    chk(irq, 1'b0);
    access(1'b1, ADDR_CTRL, 8'h08);
    wait_match;
    chk(irq, 1'b0);
  endtask
  task automatic t_duty;
    int c;
    for (c = 0; c < 8; c++) begin
      access(1'b1, ADDR_CTRL, 8'h08 | 8'(c));
      wait_match;
      wait_match;
      chk(width, 16'(3 << (c > 3 ? 4 : c)));
      chk(pwm & 8'hFE, 8'h5A);
      access(1'b1, ADDR_CTRL, 8'h00);
    end
  endtask
  task automatic t_invert;
    access(1'b1, ADDR_POL, 8'h5B);
    access(1'b1, ADDR_CTRL, 8'h08);
    chk(pwm, 8'h5B);
    wait_match;
    wait_match;
    chk(width, 16'h0007);
    access(1'b1, ADDR_CTRL, 8'h00);
  endtask
  initial begin
    repeat (4) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_regs;
    t_irq;
    t_duty;
    t_invert;
    conclude;
  end
endmodule // tb
